// ---- logic/sbwm_pkg.sv ----
/*
  Constants for the byte-lane write masking stage of a two-beat burst
  synchronous SRAM write path.
  Assumes a single 10 MHz system clock; the two documented input clock
  edges appear as two beat slots of that clock.
*/
package sbwm_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int SBWM_LANE_W = 9;
  localparam int SBWM_LANES_X18 = 2;
  localparam int SBWM_LANES_X36 = 4;
  localparam int SBWM_ADDR_W_DEF = 8;
  localparam int SBWM_BURST_LEN = 2;
  // ---------------------------------------------------------------
  // Timing (clock 10 MHz)
  // ---------------------------------------------------------------
  localparam int SBWM_CLK_PERIOD_NS = 100;
  localparam int SBWM_READ_LAT_CYC = 1;
endpackage

// ---- logic/sbwm_core.sv ----
/*
  Write path of a two-beat burst SRAM with per-lane write selects, plus
  the read port and a posted-write holding register.
  Assumes every input is synchronous to clk. The true-edge beat and the
  complementary-edge beat arrive on consecutive clk cycles, flagged by
  beat_comp.
*/
module sbwm_core
  import sbwm_pkg::*;
#(
  parameter int LANES = SBWM_LANES_X36,
  parameter int ADDR_W = SBWM_ADDR_W_DEF,
  parameter bit SINGLE_CLK = 1'b0
)
(
  input wire logic clk,                         // System clock
  input wire logic reset_n,                     // Sync reset, active low
  input wire logic request_load_n,              // Request strobe, low
  input wire logic rd_wr,                       // 1 read, 0 write
  input wire logic [ADDR_W-1:0] addr,           // Burst address
  input wire logic [LANES*SBWM_LANE_W-1:0] din, // Write data beat
  input wire logic [LANES-1:0] byte_lane_write_sel_n, // Lane selects
  output logic [LANES*SBWM_LANE_W-1:0] dout,    // Read data beat
  output logic dout_oe_n,                       // Output enable, low
  output logic dout_beat                        // Read beat index
);
  localparam int DW = LANES * SBWM_LANE_W;
  localparam int DEPTH = 1 << ADDR_W;

  // Only the x18 and x36 lane counts are served
  if (LANES != SBWM_LANES_X18 && LANES != SBWM_LANES_X36)
  begin : g_bad_lanes
    $error("LANES must be 2 or 4");
  end
  if (ADDR_W < 1 || ADDR_W > 16)
  begin : g_bad_addr
    $error("ADDR_W out of range");
  end

  // ---------------------------------------------------------------
  // Memory and posted write
  // ---------------------------------------------------------------
  logic [DW-1:0] mem [DEPTH];
  logic req_wr_d;
  logic beat_comp;
  logic [ADDR_W-1:0] wr_addr;
  logic [DW-1:0] post_data [SBWM_BURST_LEN];
  logic [LANES-1:0] post_mask [SBWM_BURST_LEN];
  logic post_valid;
  logic [ADDR_W-1:0] post_addr;
  logic rd_pend;
  logic [ADDR_W-1:0] rd_addr;
  logic rd_second;

  wire req = !request_load_n;
  wire wr_req = req && !rd_wr;
  wire rd_req = req && rd_wr;
  wire [LANES-1:0] lane_en = ~byte_lane_write_sel_n;
  wire data_beat = req_wr_d || beat_comp;
  wire [ADDR_W-1:0] beat_addr = wr_addr + ADDR_W'(beat_comp);
  // A write issued two cycles after the last one commits while that
  // burst's second beat is still arriving: take the beat from the pins
  wire [ADDR_W-1:0] post_next = post_addr + ADDR_W'(1);
  wire [DW-1:0] commit_data1 = beat_comp ? din : post_data[1];
  wire [LANES-1:0] commit_mask1 = beat_comp ? lane_en : post_mask[1];

  // Lane select expands to a 9-bit wide mask per lane
  function automatic logic [DW-1:0] lane_mask(input logic [LANES-1:0] en);
    logic [DW-1:0] m;
    m = '0;
    for (int n = 0; n < LANES; n++)
      m[n*SBWM_LANE_W +: SBWM_LANE_W] = {SBWM_LANE_W{en[n]}};
    return m;
  endfunction

  // Merge under mask: selected lanes from new data, rest kept
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w, input logic [LANES-1:0] en);
    logic [DW-1:0] m;
    m = lane_mask(en);
    return (new_w & m) | (old_w & ~m);
  endfunction

  // ---------------------------------------------------------------
  // Write sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      req_wr_d <= 1'b0;
      beat_comp <= 1'b0;
      wr_addr <= '0;
    end
    else
    begin
      req_wr_d <= wr_req;
      beat_comp <= req_wr_d;
      if (wr_req)
        wr_addr <= addr;
    end
  end

  // Beats are held; commit happens at the next write request
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      post_valid <= 1'b0;
      post_addr <= '0;
      for (int b = 0; b < SBWM_BURST_LEN; b++)
      begin
        post_data[b] <= '0;
        post_mask[b] <= '0;
      end
    end
    else
    begin
      if (data_beat)
      begin
        post_data[beat_comp] <= din;
        post_mask[beat_comp] <= lane_en;
        post_addr <= wr_addr;
        post_valid <= 1'b1;
      end
      if (wr_req && post_valid)
      begin
        mem[post_addr] <= merge(mem[post_addr], post_data[0],
          post_mask[0]);
        mem[post_next] <= merge(mem[post_next], commit_data1,
          commit_mask1);
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  wire [ADDR_W-1:0] rd_beat_addr = rd_addr + ADDR_W'(rd_second);
  wire post_hit0 = post_valid && (rd_beat_addr == post_addr);
  wire post_hit1 = post_valid && (rd_beat_addr == post_next);
  wire [DW-1:0] rd_word = post_hit0
    ? merge(mem[rd_beat_addr], post_data[0], post_mask[0])
    : post_hit1
    ? merge(mem[rd_beat_addr], post_data[1], post_mask[1])
    : mem[rd_beat_addr];
  wire rd_active = rd_pend || rd_second;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rd_pend <= 1'b0;
      rd_second <= 1'b0;
      rd_addr <= '0;
      dout <= '0;
      dout_oe_n <= 1'b1;
      dout_beat <= 1'b0;
    end
    else
    begin
      rd_pend <= rd_req;
      rd_second <= rd_pend;
      if (rd_req)
        rd_addr <= addr;
      dout_oe_n <= !rd_active;
      dout_beat <= rd_second;
      if (rd_active)
        dout <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_write_req;
    wr_req;
  endsequence
  sequence s_two_beats;
    ##1 (req_wr_d && !beat_comp) ##1 beat_comp;
  endsequence

  property p_beats_follow;
    @(posedge clk) disable iff (!reset_n) s_write_req |-> s_two_beats;
  endproperty
  a_beats_follow: assert property (p_beats_follow)
    else $error("write beats not sequenced");

  property p_beat_addr;
    @(posedge clk) disable iff (!reset_n)
      beat_comp |-> beat_addr == $past(addr, 2) + ADDR_W'(1);
  endproperty
  a_beat_addr: assert property (p_beat_addr)
    else $error("second beat address wrong");

  property p_mask_capture;
    @(posedge clk) disable iff (!reset_n)
      data_beat |=> post_mask[$past(beat_comp)]
        == ~$past(byte_lane_write_sel_n);
  endproperty
  a_mask_capture: assert property (p_mask_capture)
    else $error("lane select not captured per beat");

  property p_data_capture;
    @(posedge clk) disable iff (!reset_n)
      data_beat |=> post_data[$past(beat_comp)] == $past(din);
  endproperty
  a_data_capture: assert property (p_data_capture)
    else $error("beat data not captured");

  property p_idle_off;
    @(posedge clk) disable iff (!reset_n)
      (!rd_pend && !rd_second) |=> dout_oe_n;
  endproperty
  a_idle_off: assert property (p_idle_off)
    else $error("output driven while idle");

  property p_read_drive;
    @(posedge clk) disable iff (!reset_n)
      rd_req |=> ##1 !dout_oe_n ##1 (!dout_oe_n && dout_beat);
  endproperty
  a_read_drive: assert property (p_read_drive)
    else $error("read beats not driven");

  property p_commit;
    @(posedge clk) disable iff (!reset_n)
      (wr_req && post_valid && post_mask[0] == '0 && post_mask[1] == '0)
        |=> mem[$past(post_addr)] == $past(mem[post_addr]);
  endproperty
  a_commit: assert property (p_commit)
    else $error("masked burst changed memory");

  // Each lane of a committed first-beat word is new data or its old value
  for (genvar n = 0; n < LANES; n++)
  begin : g_lane_chk
    localparam int LO = n * SBWM_LANE_W;
    property p_full_mask;
      @(posedge clk) disable iff (!reset_n)
        (wr_req && post_valid) |=> mem[$past(post_addr)][LO +: SBWM_LANE_W]
          == ($past(post_mask[0][n])
          ? $past(post_data[0][LO +: SBWM_LANE_W])
          : $past(mem[post_addr][LO +: SBWM_LANE_W]));
    endproperty
    a_full_mask: assert property (p_full_mask)
      else $error("lane commit mismatch");
  end
endmodule

// ---- tb/sbwm_ctrl_model.sv ----
/*
  Memory controller model issuing two-beat write and read requests.
  Assumes the testbench calls its tasks; drives on falling clk edges.
*/
module sbwm_ctrl_model
  import sbwm_pkg::*;
(
  input wire logic clk, // System clock
  output logic request_load_n, // Request strobe, low
  output logic rd_wr, // 1 read, 0 write
  output logic [7:0] addr, // Burst address
  output logic [35:0] din, // Write data beat
  output logic [3:0] sel_n // Lane selects, low
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    request_load_n = 1'b1;
    rd_wr = 1'b1;
    addr = 8'h00;
    din = 36'h0;
    sel_n = 4'hF;
  end
  // One-cycle request strobe, then qualifiers turned over
  task req(input logic r, input logic [7:0] a);
    @(negedge clk);
    request_load_n = 1'b0;
    rd_wr = r;
    addr = a;
    @(negedge clk);
    request_load_n = 1'b1;
    rd_wr = ~r;
    addr = ~a;
  endtask
  task wr(input logic [7:0] a, input logic [35:0] d0, d1,
    input logic [3:0] s0, s1);
    req(1'b0, a);
    din = d0;
    sel_n = s0;
    @(negedge clk);
    din = d1;
    sel_n = s1;
    @(negedge clk);
    din = ~d1;
    sel_n = ~s1;
  endtask
endmodule

// ---- tb/sbwm_core_tb.sv ----
/*
  Self-checking bench for the lane write masking path, x36 and x18.
  Assumes the controller model drives both cores; reads forward posted data.
*/
module sbwm_core_tb
  import sbwm_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic load_n, rd_wr, oe_n, oe18_n, beat, beat18;
  logic [7:0] addr;
  logic [35:0] din, dout;
  logic [3:0] sel_n;
  logic [17:0] dout18;
  int fail_count = 0;
  int n_checks = 0;
  logic [7:0] rows [6] = '{8'h0F, 8'hED, 8'hB7, 8'hF0, 8'hEB, 8'hD7};
  logic [35:0] b0, n0;
  logic [7:0] a;
  sbwm_ctrl_model ctrl (.clk(clk), .request_load_n(load_n), .rd_wr(rd_wr),
    .addr(addr), .din(din), .sel_n(sel_n));
  sbwm_core #(.LANES(4)) sbwm_core_i (.clk(clk), .reset_n(reset_n),
    .request_load_n(load_n), .rd_wr(rd_wr), .addr(addr), .din(din),
    .byte_lane_write_sel_n(sel_n), .dout(dout), .dout_oe_n(oe_n),
    .dout_beat(beat));
  sbwm_core #(.LANES(2)) sbwm_core_x18_i (.clk(clk), .reset_n(reset_n),
    .request_load_n(load_n), .rd_wr(rd_wr), .addr(addr), .din(din[17:0]),
    .byte_lane_write_sel_n(sel_n[1:0]), .dout(dout18), .dout_oe_n(oe18_n),
    .dout_beat(beat18));
  initial
  begin
    forever #(SBWM_CLK_PERIOD_NS / 2) clk = ~clk;
  end
  function automatic logic [35:0] mrg(logic [35:0] o, n, logic [3:0] s);
    logic [35:0] m;
    for (int k = 0; k < 4; k++) m[9*k +: 9] = {9{~s[k]}};
    return (o & ~m) | (n & m);
  endfunction
  task chk(input logic [35:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task rd_chk(input logic [7:0] ra, input logic [35:0] e0, e1);
    ctrl.req(1'b1, ra);
    repeat (SBWM_READ_LAT_CYC) @(negedge clk);
    chk(dout, e0);
    chk({18'h0, dout18}, {18'h0, e0[17:0]});
    chk({34'h0, oe_n, beat}, 36'h0);
    @(negedge clk);
    chk(dout, e1);
    chk({18'h0, dout18}, {18'h0, e1[17:0]});
    chk({34'h0, oe18_n, beat18}, 36'h1);
    @(negedge clk);
    chk({35'h0, oe_n}, 36'h1);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #(3000 * SBWM_CLK_PERIOD_NS);
    fail_count++;
    close_out;
  end
  initial
  begin
    repeat (2) @(negedge clk);
    chk({dout[34:0], oe_n}, 36'h1);
    reset_n = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      a = 8'hFF - 8'(2 * i);
      b0 = 36'h123456789 + 36'(i);
      n0 = 36'hABCDE1234 ^ 36'(i);
      ctrl.wr(a, b0, ~b0, 4'h0, 4'h0);
      ctrl.wr(a, n0, ~n0, rows[i][7:4], rows[i][3:0]);
      rd_chk(a, mrg(b0, n0, rows[i][7:4]),
        mrg(~b0, ~n0, rows[i][3:0]));
      $display("test row %0d done", i);
    end
    // Posted write must survive a read and commit on the next write
    ctrl.wr(8'h10, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
    ctrl.wr(8'h10, 36'h0, 36'hFFFFFFFFF, 4'hE, 4'h7);
    rd_chk(8'h10, 36'h111111000, 36'hFFA222222);
    ctrl.wr(8'h40, 36'h333333333, 36'h444444444, 4'h0, 4'h0);
    rd_chk(8'h10, 36'h111111000, 36'hFFA222222);
    $display("test posted write done");
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    chk({dout[34:0], oe_n}, 36'h1);
    chk({17'h0, dout18, oe18_n}, 36'h1);
    reset_n = 1'b1;
    $display("test reset done");
    // Fully masked burst right after reset must leave the array intact
    ctrl.wr(8'h10, 36'h555555555, 36'h666666666, 4'hF, 4'hF);
    ctrl.wr(8'h20, 36'h0, 36'h0, 4'h0, 4'h0);
    rd_chk(8'h10, 36'h111111000, 36'hFFA222222);
    $display("test masked burst done");
    close_out;
  end
endmodule
